// File: bench/lct_ctl_model.sv
// Controller-side model driving loop occupancy and phase green lines
`timescale 1ns/1ps
module lct_ctl_model (
  input  wire logic       clk_i,
  output logic      [1:0] occ_o,
  output logic      [1:0] green_n_o
);
  // ==========================================================
  // Line state: loops empty, phase not green
  initial
  begin
    occ_o     = 2'h0;
    green_n_o = 2'h3;
  end

  // Occupancy changes just after a clock edge
  task automatic set_occ(input int ch, input logic v);
    @(posedge clk_i);
    occ_o[ch] <= v;
  endtask : set_occ

  // Green is active low on the line
  task automatic set_green(input int ch, input logic on);
    @(posedge clk_i);
    green_n_o[ch] <= ~on;
  endtask : set_green
endmodule : lct_ctl_model

// File: bench/testbench.sv
// Self-checking bench for the loop detector call timing block
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Clock, reset and connections
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [5:0]  wb_adr = 6'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] rd_dat;
  logic        wb_ack;
  logic [1:0]  occ;
  logic [1:0]  green_n;
  logic [1:0]  call_o;
  logic [1:0]  osc_en;
  logic [5:0]  freq;
  logic [7:0]  sens;
  logic        d_ind;
  logic        d_dl;
  logic [31:0] q;
  logic [1:0]  fail = 2'h0;
  logic [15:0] dl = 16'h0000;
  int          errors = 0;
  int          num_checks = 0;
  int          n;

  always #2 clk_i = ~clk_i;

  lct_top #(.TICK_CYC(20), .PULSE_CYC(30)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(rd_dat), .wb_ack_o(wb_ack),
    .occ_i(occ), .green_n_i(green_n), .loop_fail_i(fail),
    .dl_i(dl), .call_o(call_o), .osc_en_o(osc_en),
    .freq_sel_o(freq), .sens_o(sens), .disp_ind_o(d_ind),
    .disp_dl_o(d_dl));

  lct_ctl_model PART (.clk_i(clk_i), .occ_o(occ), .green_n_o(green_n));

  // ==========================================================
  // Bus access, waits and comparison
  task automatic wb(input logic we, input logic [5:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = rd_dat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %0t %s got %h", $time, m, got);
    end
  endtask : chk

  // Counts call cycles on channel 0 over a fixed window
  task automatic pulse_len();
    n = 0;
    repeat (100)
    begin
      @(posedge clk_i);
      if (call_o[0] === 1'b1) n++;
    end
  endtask : pulse_len

  task automatic end_sim();
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Watchdog
  initial
  begin
    cyc(20000);
    errors++;
    end_sim();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    cyc(3);
    rst_i <= 1'b0;
    cyc(4);
    chk(sens, 8'h44, "sens reset");
    chk(call_o, 2'h0, "call reset");
    wb(1'b0, 6'h30, 32'h0);
    chk(q, 32'h0, "unmapped read");
    // Forced call, channel off, levels and frequency
    wb(1'b1, 6'h00, 32'h0000_0079);
    wb(1'b1, 6'h10, 32'h0000_000a);
    PART.set_occ(1, 1'b1);
    cyc(8);
    chk({call_o, osc_en}, 4'h4, "forced/off call");
    chk(freq[2:0], 3'h7, "freq field");
    wb(1'b1, 6'h10, 32'h0000_0008);
    wb(1'b1, 6'h10, 32'h0000_000b);
    cyc(2);
    chk(sens[7:4], 4'h8, "sens level");
    PART.set_occ(1, 1'b0);
    // Call delay of one second, then green override
    wb(1'b1, 6'h00, 32'h0000_0004);
    wb(1'b1, 6'h04, 32'h0000_0001);
    PART.set_occ(0, 1'b1);
    cyc(100);
    chk(call_o[0], 1'b0, "delay withheld");
    cyc(150);
    chk(call_o[0], 1'b1, "delay expired");
    PART.set_occ(0, 1'b0);
    cyc(10);
    PART.set_occ(0, 1'b1);
    cyc(20);
    PART.set_green(0, 1'b1);
    cyc(10);
    chk(call_o[0], 1'b1, "green abort");
    PART.set_occ(0, 1'b0);
    PART.set_green(0, 1'b0);
    // Extension of 0.5 s with re-entry
    wb(1'b1, 6'h04, 32'h0000_0500);
    PART.set_occ(0, 1'b1);
    cyc(10);
    PART.set_occ(0, 1'b0);
    cyc(60);
    chk(call_o[0], 1'b1, "extension hold");
    PART.set_occ(0, 1'b1);
    cyc(10);
    PART.set_occ(0, 1'b0);
    cyc(60);
    chk(call_o[0], 1'b1, "extension reload");
    cyc(70);
    chk(call_o[0], 1'b0, "extension end");
    // Gated extension with green inactive, then active
    wb(1'b1, 6'h00, 32'h0000_0404);
    PART.set_occ(0, 1'b1);
    cyc(10);
    PART.set_occ(0, 1'b0);
    cyc(20);
    chk(call_o[0], 1'b0, "gated extension");
    PART.set_green(0, 1'b1);
    PART.set_occ(0, 1'b1);
    cyc(10);
    PART.set_occ(0, 1'b0);
    cyc(20);
    chk(call_o[0], 1'b1, "green extension");
    PART.set_green(0, 1'b0);
    // Pulse mode, dwell tune-out and a second vehicle
    wb(1'b1, 6'h00, 32'h0000_0104);
    PART.set_occ(0, 1'b1);
    pulse_len();
    chk(n, 30, "pulse width");
    cyc(350);
    wb(1'b0, 6'h0c, 32'h0);
    chk(q[4], 1'b1, "tuned out");
    PART.set_occ(0, 1'b0);
    cyc(10);
    wb(1'b0, 6'h0c, 32'h0);
    chk(q[4], 1'b0, "sensitivity back");
    PART.set_occ(0, 1'b1);
    pulse_len();
    chk(n, 30, "second pulse");
    PART.set_occ(0, 1'b0);
    // Max presence expiry without and with end-of-phase sync
    wb(1'b1, 6'h00, 32'h0000_0004);
    wb(1'b1, 6'h04, 32'h0000_0000);
    wb(1'b1, 6'h08, 32'h0000_0001);
    PART.set_occ(0, 1'b1);
    cyc(10);
    chk(call_o[0], 1'b1, "call start");
    cyc(250);
    chk(call_o[0], 1'b0, "max presence reset");
    PART.set_occ(0, 1'b0);
    wb(1'b1, 6'h00, 32'h0000_0204);
    PART.set_green(0, 1'b1);
    PART.set_occ(0, 1'b1);
    cyc(260);
    wb(1'b0, 6'h0c, 32'h0);
    chk(q[3:0], 4'hc, "wait state");
    fail <= 2'h1;
    PART.set_green(0, 1'b0);
    cyc(10);
    chk(call_o[0], 1'b1, "failed channel held");
    fail <= 2'h0;
    PART.set_green(0, 1'b1);
    cyc(10);
    PART.set_green(0, 1'b0);
    cyc(10);
    chk(call_o[0], 1'b0, "green end reset");
    PART.set_occ(0, 1'b0);
    // Display option
    wb(1'b1, 6'h20, 32'h0000_0003);
    cyc(2);
    chk({d_ind, d_dl}, 2'h3, "displays on");
    // Peak change held for 2 s during a call, then follows the input
    dl <= 16'h0033;
    PART.set_occ(0, 1'b1);
    cyc(10);
    dl <= 16'h0011;
    cyc(10);
    wb(1'b0, 6'h0c, 32'h0);
    chk(q[15:8], 8'h33, "peak held");
    cyc(450);
    wb(1'b0, 6'h0c, 32'h0);
    chk(q[15:8], 8'h11, "peak released");
    PART.set_occ(0, 1'b0);
    end_sim();
  end
endmodule : testbench

// File: rtl/lct_pkg.sv
// Constants and types shared by the loop detector call timing block
package lct_pkg;
  // ==========================================================
  // Channel count and register map
  localparam int          NCH        = 2;
  localparam logic [5:0]  OFS_CFG    = 6'h00;
  localparam logic [5:0]  OFS_TIM    = 6'h04;
  localparam logic [5:0]  OFS_MAXP   = 6'h08;
  localparam logic [5:0]  OFS_STAT   = 6'h0c;
  localparam logic [5:0]  CH_STRIDE  = 6'h10;
  localparam logic [5:0]  OFS_DISP   = 6'h20;
  // ==========================================================
  // Field positions
  localparam int          CFG_FREQ_LSB  = 4;
  localparam int          CFG_PULSE_BIT = 8;
  localparam int          CFG_SYNC_BIT  = 9;
  localparam int          CFG_XGATE_BIT = 10;
  localparam int          TIM_EXT_LSB   = 8;
  localparam int          STAT_CALL_BIT = 3;
  localparam int          STAT_TUNE_BIT = 4;
  localparam int          STAT_FAIL_BIT = 5;
  localparam int          STAT_PK_LSB   = 8;
  // ==========================================================
  // Setting codes and reset values
  localparam logic [3:0]  SENS_MAX   = 4'h8;
  localparam logic [3:0]  SENS_FORCE = 4'h9;
  localparam logic [3:0]  SENS_OFF   = 4'ha;
  localparam logic [3:0]  SENS_RST   = 4'h4;
  localparam logic [2:0]  FREQ_RST   = 3'h0;
  localparam logic [9:0]  MAXP_LIM   = 10'h3e7;
  // ==========================================================
  // Timing, in its own units and in ticks
  localparam int          CLK_MHZ      = 250;
  localparam int          TICK_MS      = 100;
  localparam int          PULSE_MS     = 125;
  localparam int          TICK_CYC_DEF = TICK_MS * CLK_MHZ * 1000;
  localparam int          PULSE_CYC_DEF = PULSE_MS * CLK_MHZ * 1000;
  localparam int          DWELL_MS     = 2000;
  localparam int          PEAK_MS      = 2000;
  localparam int          DISP_MIN     = 15;
  localparam logic [13:0] SEC_TICKS    = 14'(1000 / TICK_MS);
  localparam logic [4:0]  TUNE_TICKS   = 5'(DWELL_MS / TICK_MS);
  localparam logic [4:0]  PEAK_TICKS   = 5'(PEAK_MS / TICK_MS);
  localparam logic [13:0] DISP_TICKS   = 14'(DISP_MIN * 60000 / TICK_MS);
  // ==========================================================
  // Channel states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_DELAY = 3'h1,
    ST_CALL  = 3'h2,
    ST_EXT   = 3'h3,
    ST_WAIT  = 3'h4
  } lct_state_t;
endpackage : lct_pkg

// File: rtl/lct_top.sv
// Two channel call timing core with Wishbone register access
//
// Contract
// - Forced-call setting keeps call asserted and oscillator off.
// - Disabled setting keeps call deasserted and oscillator off.
// - Sensitivity per channel: nine levels plus forced and disabled.
// - Loop frequency per channel: eight settings.
// - Call delay 0..255 s from zone entry withholds the call.
// - Active green aborts running delay; delay counts as zero.
// - Call extension 0..25.5 s from last exit holds the call.
// - Entry during extension returns to detect; full extension later.
// - Presence holds call at least 4 min; pulse excludes presence.
// - Pulse mode: one 125 ms pulse per entering vehicle.
// - Pulse mode: vehicle dwelling over 2 s is tuned out.
// - Pulse mode: full sensitivity within 0.5 s after exit.
// - Max presence 1..999 s or off, starts when call begins.
// - Vacancy before max presence expiry drops call, no reset.
// - Sync off: expiry with call present resets channel.
// - Sync on: expiry waits; vacancy drops, green end resets.
// - End-of-phase sync only usable while max presence is set.
// - Out-of-range loop failure blocks green-end reset; stays failed.
// - Inductance display both channels, off after 15 minutes.
// - Change display holds peak 2 s, off after 15 minutes.
// - Extension gating: extend only while phase green is active; green is checked only at exit, and a started extension runs out in full.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module lct_top #(
  parameter int TICK_CYC  = lct_pkg::TICK_CYC_DEF,
  parameter int PULSE_CYC = lct_pkg::PULSE_CYC_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  occ_i,
  input  wire logic [1:0]  green_n_i,
  input  wire logic [1:0]  loop_fail_i,
  input  wire logic [15:0] dl_i,
  output logic      [1:0]  call_o,
  output logic      [1:0]  osc_en_o,
  output logic      [5:0]  freq_sel_o,
  output logic      [7:0]  sens_o,
  output logic             disp_ind_o,
  output logic             disp_dl_o
);
  localparam int NCH = lct_pkg::NCH;
  if (TICK_CYC < 2 || TICK_CYC > 33554431) $error("TICK_CYC out of range");
  if (PULSE_CYC < 2 || PULSE_CYC > 33554431) $error("PULSE_CYC bad");

  // Tick count converted from seconds
  function automatic logic [13:0] sec_to_ticks(input logic [9:0] s);
    sec_to_ticks = 14'(s) * lct_pkg::SEC_TICKS;
  endfunction : sec_to_ticks

  // Byte-lane merge for register writes
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [1:0]  sel,
                                          input logic [15:0] dat);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge16

  // ==========================================================
  // Input synchronisers
  logic [1:0]  occ_m, occ_s, grn_m, grn_s, grn_d, fail_m, fail_s;
  logic [15:0] dl_m, dl_s;
  always_ff @(posedge clk_i) begin
    occ_m  <= occ_i;
    occ_s  <= occ_m;
    grn_m  <= green_n_i;
    grn_s  <= grn_m;
    grn_d  <= grn_s;
    fail_m <= loop_fail_i;
    fail_s <= fail_m;
    dl_m   <= dl_i;
    dl_s   <= dl_m;
  end

  // ==========================================================
  // Base tick
  logic [24:0] tk_cnt_r;
  logic        tick_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || tk_cnt_r == 25'(TICK_CYC - 1))
    begin
      tk_cnt_r <= '0;
      tick_r   <= ~rst_i;
    end
    else
    begin
      tk_cnt_r <= tk_cnt_r + 25'h1;
      tick_r   <= 1'b0;
    end
  end

  // ==========================================================
  // Registers
  logic [NCH-1:0][3:0] sens_r;
  logic [NCH-1:0][2:0] freq_r;
  logic [NCH-1:0]      pmode_r, psync_r, xgate_r;
  logic [NCH-1:0][7:0] dly_r, ext_r, pk_r;
  logic [NCH-1:0][9:0] maxp_r;
  logic                ack_r, dind_r, ddl_r;
  logic [13:0]         dind_tm, ddl_tm;
  logic                wr_en;
  logic [3:0]          ch_sel;
  logic [1:0]          ch_off;
  assign wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign ch_sel = wb_adr_i[5:2];
  assign ch_off = wb_adr_i[4] ? 2'h1 : 2'h0;

  // Bus handshake, ack one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
  end

  // Channel setting writes, taken on the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i)
    begin
      sens_r  <= {NCH{lct_pkg::SENS_RST}};
      freq_r  <= {NCH{lct_pkg::FREQ_RST}};
      pmode_r <= '0;
      psync_r <= '0;
      xgate_r <= '0;
      dly_r   <= '0;
      ext_r   <= '0;
      maxp_r  <= '0;
    end
    else if (wr_en && !wb_adr_i[5])
    begin
      for (int c = 0; c < NCH; c++)
        if (wb_adr_i[4] == c[0])
        begin
          if (ch_sel[1:0] == lct_pkg::OFS_CFG[3:2])
          begin
            if (wb_sel_i[0] && wb_dat_i[3:0] <= lct_pkg::SENS_OFF)
              sens_r[c] <= wb_dat_i[3:0];
            if (wb_sel_i[0])
              freq_r[c] <= wb_dat_i[lct_pkg::CFG_FREQ_LSB +: 3];
            if (wb_sel_i[1])
            begin
              pmode_r[c] <= wb_dat_i[lct_pkg::CFG_PULSE_BIT];
              psync_r[c] <= wb_dat_i[lct_pkg::CFG_SYNC_BIT];
              xgate_r[c] <= wb_dat_i[lct_pkg::CFG_XGATE_BIT];
            end
          end
          if (ch_sel[1:0] == lct_pkg::OFS_TIM[3:2])
            {ext_r[c], dly_r[c]} <= merge16({ext_r[c], dly_r[c]},
                                            wb_sel_i[1:0], wb_dat_i[15:0]);
          if (ch_sel[1:0] == lct_pkg::OFS_MAXP[3:2]
              && wb_dat_i[9:0] <= lct_pkg::MAXP_LIM && wb_sel_i[1:0] == 2'h3)
            maxp_r[c] <= wb_dat_i[9:0];
        end
    end
  end

  // Display options with their 15 minute self-off
  always_ff @(posedge clk_i) begin
    if (rst_i)
    begin
      dind_r  <= 1'b0;
      ddl_r   <= 1'b0;
      dind_tm <= '0;
      ddl_tm  <= '0;
    end
    else if (wr_en && {ch_sel, 2'h0} == lct_pkg::OFS_DISP && wb_sel_i[0])
    begin
      dind_r  <= wb_dat_i[0];
      ddl_r   <= wb_dat_i[1];
      dind_tm <= lct_pkg::DISP_TICKS;
      ddl_tm  <= lct_pkg::DISP_TICKS;
    end
    else if (tick_r)
    begin
      if (dind_tm != '0) dind_tm <= dind_tm - 14'h1;
      if (ddl_tm != '0) ddl_tm <= ddl_tm - 14'h1;
      if (dind_tm == 14'h1) dind_r <= 1'b0;
      if (ddl_tm == 14'h1) ddl_r <= 1'b0;
    end
  end

  // ==========================================================
  // Channel decisions
  lct_pkg::lct_state_t [NCH-1:0] st_r;
  logic [NCH-1:0][13:0] tm_r, mp_r;
  logic [NCH-1:0]       tuned_r, forced, chan_off, occ_v, green, gfall;
  logic [NCH-1:0]       start, mp_exp, mp_rst, psync_rst, psync_on, ext_go;
  logic [NCH-1:0]       call_r, osc_r, pls_on, occ_d;
  logic [NCH-1:0][24:0] pls_cnt;
  logic [NCH-1:0][4:0]  dwell_r, pk_tm;
  always_comb begin
    for (int c = 0; c < NCH; c++)
    begin
      forced[c]   = sens_r[c] == lct_pkg::SENS_FORCE;
      chan_off[c] = sens_r[c] == lct_pkg::SENS_OFF;
      occ_v[c]    = occ_s[c] && !tuned_r[c];
      green[c]    = !grn_s[c];
      gfall[c]    = grn_s[c] && !grn_d[c];
      psync_on[c] = psync_r[c] && maxp_r[c] != '0;
      ext_go[c]   = ext_r[c] != '0 && (!xgate_r[c] || green[c]);
      mp_exp[c]   = maxp_r[c] != '0 && mp_r[c] == '0;
      start[c]    = occ_v[c] && ((st_r[c] == lct_pkg::ST_IDLE
                    && (dly_r[c] == '0 || green[c]))
                    || (st_r[c] == lct_pkg::ST_DELAY && (green[c]
                    || (tick_r && tm_r[c] == 14'h1))));
      mp_rst[c]   = st_r[c] == lct_pkg::ST_CALL && occ_v[c] && mp_exp[c]
                    && !psync_on[c];
      psync_rst[c] = st_r[c] == lct_pkg::ST_WAIT && occ_v[c] && gfall[c]
                    && !fail_s[c];
    end
  end

  // Presence state machine per channel
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++)
    begin
      if (rst_i || forced[c] || chan_off[c] || pmode_r[c])
      begin
        st_r[c] <= lct_pkg::ST_IDLE;
        tm_r[c] <= '0;
      end
      else
        case (st_r[c])
          lct_pkg::ST_IDLE:
            if (start[c])
              st_r[c] <= lct_pkg::ST_CALL;
            else if (occ_v[c])
            begin
              st_r[c] <= lct_pkg::ST_DELAY;
              tm_r[c] <= sec_to_ticks({2'h0, dly_r[c]});
            end
          lct_pkg::ST_DELAY:
            if (start[c])
              st_r[c] <= lct_pkg::ST_CALL;
            else if (!occ_v[c])
              st_r[c] <= lct_pkg::ST_IDLE;
            else if (tick_r)
              tm_r[c] <= tm_r[c] - 14'h1;
          lct_pkg::ST_CALL:
            if (!occ_v[c] && ext_go[c])
            begin
              st_r[c] <= lct_pkg::ST_EXT;
              tm_r[c] <= {6'h0, ext_r[c]};
            end
            else if (!occ_v[c] || mp_rst[c])
              st_r[c] <= lct_pkg::ST_IDLE;
            else if (mp_exp[c])
              st_r[c] <= lct_pkg::ST_WAIT;
          lct_pkg::ST_EXT:
            if (occ_v[c])
              st_r[c] <= lct_pkg::ST_CALL;
            else if (tick_r && tm_r[c] <= 14'h1)
              st_r[c] <= lct_pkg::ST_IDLE;
            else if (tick_r)
              tm_r[c] <= tm_r[c] - 14'h1;
          lct_pkg::ST_WAIT:
            if (!occ_v[c] || psync_rst[c])
              st_r[c] <= lct_pkg::ST_IDLE;
          default:
            st_r[c] <= lct_pkg::ST_IDLE;
        endcase
    end
  end

  // Max presence countdown, loaded as each call begins
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++)
      if (rst_i)
        mp_r[c] <= '0;
      else if (start[c])
        mp_r[c] <= sec_to_ticks(maxp_r[c]);
      else if (tick_r && mp_r[c] != '0)
        mp_r[c] <= mp_r[c] - 14'h1;
  end

  // Tune-out: automatic reset or long pulse dwell, cleared on vacancy
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++)
      if (rst_i || !occ_s[c])
      begin
        tuned_r[c] <= 1'b0;
        dwell_r[c] <= '0;
      end
      else if (mp_rst[c] || psync_rst[c])
        tuned_r[c] <= 1'b1;
      else if (pmode_r[c] && tick_r && !tuned_r[c])
      begin
        dwell_r[c] <= dwell_r[c] + 5'h1;
        if (dwell_r[c] == lct_pkg::TUNE_TICKS - 5'h1)
          tuned_r[c] <= 1'b1;
      end
  end

  // Pulse generator, one pulse per entering vehicle
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++)
      if (rst_i)
      begin
        occ_d[c]   <= 1'b0;
        pls_cnt[c] <= '0;
      end
      else
      begin
        occ_d[c] <= occ_v[c];
        if (pmode_r[c] && occ_v[c] && !occ_d[c])
          pls_cnt[c] <= 25'(PULSE_CYC);
        else if (pls_cnt[c] != '0)
          pls_cnt[c] <= pls_cnt[c] - 25'h1;
      end
  end
  always_comb begin
    for (int c = 0; c < NCH; c++)
      pls_on[c] = pls_cnt[c] != '0;
  end

  // Peak change hold for the change display
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++)
      if (rst_i || !ddl_r || !call_r[c])
      begin
        pk_r[c]  <= '0;
        pk_tm[c] <= '0;
      end
      else if (dl_s[8*c +: 8] > pk_r[c] || pk_tm[c] == '0)
      begin
        pk_r[c]  <= dl_s[8*c +: 8];
        pk_tm[c] <= lct_pkg::PEAK_TICKS;
      end
      else if (tick_r)
        pk_tm[c] <= pk_tm[c] - 5'h1;
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCH; c++)
      if (rst_i)
      begin
        call_r[c] <= 1'b0;
        osc_r[c]  <= 1'b0;
      end
      else
      begin
        osc_r[c] <= !forced[c] && !chan_off[c];
        if (forced[c] || chan_off[c])
          call_r[c] <= forced[c];
        else if (pmode_r[c])
          call_r[c] <= pls_on[c];
        else
          call_r[c] <= st_r[c] == lct_pkg::ST_CALL || st_r[c] ==
                       lct_pkg::ST_EXT || st_r[c] == lct_pkg::ST_WAIT;
      end
  end
  assign call_o     = call_r;
  assign osc_en_o   = osc_r;
  assign freq_sel_o = {freq_r[1], freq_r[0]};
  assign sens_o     = {sens_r[1], sens_r[0]};
  assign disp_ind_o = dind_r;
  assign disp_dl_o  = ddl_r;
  assign wb_ack_o   = ack_r;

  // Read data, captured with the ack
  always_ff @(posedge clk_i) begin
    wb_dat_o <= '0;
    if (!rst_i && wb_cyc_i && wb_stb_i && !ack_r && !wb_adr_i[5])
      case ({2'h0, ch_sel[1:0], 2'h0})
        lct_pkg::OFS_CFG:  wb_dat_o <= {21'h0, xgate_r[ch_off[0]],
                             psync_r[ch_off[0]], pmode_r[ch_off[0]], 1'b0,
                             freq_r[ch_off[0]], sens_r[ch_off[0]]};
        lct_pkg::OFS_TIM:  wb_dat_o <= {16'h0, ext_r[ch_off[0]],
                             dly_r[ch_off[0]]};
        lct_pkg::OFS_MAXP: wb_dat_o <= {22'h0, maxp_r[ch_off[0]]};
        lct_pkg::OFS_STAT: wb_dat_o <= {16'h0, pk_r[ch_off[0]], 2'h0,
                             fail_s[ch_off[0]], tuned_r[ch_off[0]],
                             call_r[ch_off[0]], st_r[ch_off[0]]};
        default:           wb_dat_o <= '0;
      endcase
    else if (!rst_i && wb_cyc_i && wb_stb_i && !ack_r
             && {ch_sel, 2'h0} == lct_pkg::OFS_DISP)
      wb_dat_o <= {30'h0, ddl_r, dind_r};
  end

  // ==========================================================
  // Checks on channel 0 and on the inductance display self-off
  sequence s_forced2;
    forced[0] [*2];
  endsequence
  property p_forced;
    @(posedge clk_i) disable iff (rst_i)
      s_forced2 |-> call_o[0] && !osc_en_o[0];
  endproperty
  a_forced: assert property (p_forced) else $error("forced call lost");
  property p_off;
    @(posedge clk_i) disable iff (rst_i)
      chan_off[0] [*2] |-> !call_o[0] && !osc_en_o[0];
  endproperty
  a_off: assert property (p_off) else $error("disabled channel calls");
  property p_sens;
    @(posedge clk_i) disable iff (rst_i) sens_r[0] <= lct_pkg::SENS_OFF;
  endproperty
  a_sens: assert property (p_sens) else $error("bad sensitivity");
  property p_green;
    @(posedge clk_i) disable iff (rst_i)
      st_r[0] == lct_pkg::ST_DELAY && occ_v[0] && green[0]
      && !forced[0] && !chan_off[0] && !pmode_r[0]
      |=> st_r[0] == lct_pkg::ST_CALL;
  endproperty
  a_green: assert property (p_green) else $error("delay not aborted");
  sequence s_reenter;
    st_r[0] == lct_pkg::ST_EXT && occ_v[0] && !pmode_r[0] && osc_r[0];
  endsequence
  property p_reenter;
    @(posedge clk_i) disable iff (rst_i)
      s_reenter |=> st_r[0] == lct_pkg::ST_CALL ##1 call_o[0];
  endproperty
  a_reenter: assert property (p_reenter) else $error("no redetect");
  property p_pulse;
    @(posedge clk_i) disable iff (rst_i)
      $rose(pls_on[0]) |-> pls_cnt[0] == 25'(PULSE_CYC);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_maxp;
    @(posedge clk_i) disable iff (rst_i)
      mp_rst[0] && !forced[0] && !chan_off[0] && !pmode_r[0]
      |=> st_r[0] == lct_pkg::ST_IDLE && (tuned_r[0] || !occ_s[0]);
  endproperty
  a_maxp: assert property (p_maxp) else $error("no auto reset");
  property p_fail;
    @(posedge clk_i) disable iff (rst_i)
      st_r[0] == lct_pkg::ST_WAIT && fail_s[0] && occ_v[0] && osc_r[0]
      && !pmode_r[0] |=> st_r[0] == lct_pkg::ST_WAIT;
  endproperty
  a_fail: assert property (p_fail) else $error("failed channel reset");
  property p_disp;
    @(posedge clk_i) disable iff (rst_i)
      dind_tm == 14'h1 && tick_r |=> !disp_ind_o;
  endproperty
  a_disp: assert property (p_disp) else $error("display not off");
endmodule : lct_top
